// File: hdl/adv_timer_counter_core.sv
/*
  counter core of a four-channel advanced timer: clock source select,
  16-bit prescaler, 16-bit up/down/center-aligned counter with repetition.
  assumes configuration ports are quasi-static levels from the same clock
  domain; pins and trigger inputs are asynchronous.
*/
// Functional notes
// - counter is sixteen bits wide and unsigned
// - source select zero counts every kernel clock cycle
// - select 5,6,7 take channel 0/1 pin edges as timer clock
// - select 1 to 4 take rising edges of internal triggers 0 to 3
// - mode-1 bit or select 8 picks the external trigger input
// - external trigger input is filtered; each rising edge gives one tick
// - prescaler divides by any factor from 1 to 65536
// - new prescaler value takes effect only at the next update event
// - prescaler runs only while the counter-run bit is set
// - up mode counts 0 to reload then wraps to 0 with overflow
// - update after repetition-plus-one overflows in up mode
// - update-generate in up mode clears counter and raises update
// - down mode counts reload to 0 then reloads with underflow
// - update after repetition-plus-one underflows in down mode
// - update-generate in down mode loads reload value and updates
// - update-disable suppresses update events in every mode
// - update copies repetition, reload and prescaler into active copies
// - center mode counts 0 up to reload and back down to 0
// - center mode underflows at 1 going down, overflows at reload-1 up
// - center mode direction is read-only and shows actual direction
// - center mode update-generate clears counter and raises update
// - center mode update flag sets on overflow and underflow
`timescale 1ns/1ns
`default_nettype none
module adv_timer_counter_core
  import adv_timer_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  // clock source
  input  wire logic [3:0]   i_timer_source_select,
  input  wire logic         i_ext_clock_mode1_enable,
  input  wire logic [3:0]   i_internal_trigger_inputs,
  input  wire logic         i_ch0_in,
  input  wire logic         i_ch1_in,
  input  wire logic         i_external_trigger_input,
  // control
  input  wire logic         i_counter_run,
  input  wire logic         i_dir,
  input  wire logic         i_center_align_select,
  input  wire logic         i_update_disable,
  input  wire logic         i_update_generate,
  input  wire logic         i_update_flag_clear,
  input  wire logic [W-1:0] i_prescaler_value,
  input  wire logic [W-1:0] i_auto_reload_value,
  input  wire logic [7:0]   i_repetition_value,
  // status
  output logic [W-1:0]      o_count,
  output logic              o_dir,
  output logic              o_update_event,
  output logic              o_update_flag,
  output logic              o_overflow,
  output logic              o_underflow
);
  typedef struct packed {
    logic [3:0]   iti_s1;
    logic [3:0]   iti_s2;
    logic [3:0]   iti_s3;
    logic [1:0]   ch_s1;
    logic [1:0]   ch_s2;
    logic [1:0]   ch_s3;
    logic         eti_prev;
    logic [W-1:0] psc_cnt;
    logic [W-1:0] psc_act;
    logic [W-1:0] arr_act;
    logic [7:0]   rep_act;
    logic [7:0]   rep_cnt;
    logic [W-1:0] cnt;
    dir_state_t   dir;
    logic         upd;
    logic         flag;
    logic         ovf;
    logic         udf;
  } core_state_t;

  core_state_t cur;
  core_state_t next_cur;
  logic        eti_level;
  logic        tick;
  logic        cnt_clk;
  logic        wrap;
  logic        ovf_ev;
  logic        udf_ev;
  logic        upd_ev;
  logic [3:0]  sel;

  adv_timer_sync_filter #(
    .FILT_LEN (FILT_LEN_DEF)
  ) u_eti_filter (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pin     (i_external_trigger_input),
    .o_level   (eti_level)
  );

  always_comb begin
    next_cur = cur;
    sel      = i_timer_source_select;
    // pins pass three flops; an edge counts when stages two and three differ
    next_cur.iti_s1 = i_internal_trigger_inputs;
    next_cur.iti_s2 = cur.iti_s1;
    next_cur.iti_s3 = cur.iti_s2;
    next_cur.ch_s1  = {i_ch1_in, i_ch0_in};
    next_cur.ch_s2  = cur.ch_s1;
    next_cur.ch_s3  = cur.ch_s2;
    next_cur.eti_prev = eti_level;
    tick = 1'b0;
    if (i_ext_clock_mode1_enable || sel == SRC_ETI) begin
      tick = eti_level && !cur.eti_prev;
    end else if (sel == SRC_KERNEL) begin
      tick = 1'b1;
    end else if (sel >= SRC_ITI0 && sel <= SRC_ITI3) begin
      tick = cur.iti_s2[2'(sel - SRC_ITI0)]
             && !cur.iti_s3[2'(sel - SRC_ITI0)];
    end else if (sel == SRC_CH0_RISE) begin
      tick = cur.ch_s2[0] && !cur.ch_s3[0];
    end else if (sel == SRC_CH0_FALL) begin
      tick = !cur.ch_s2[0] && cur.ch_s3[0];
    end else if (sel == SRC_CH1_RISE) begin
      tick = cur.ch_s2[1] && !cur.ch_s3[1];
    end else begin
      tick = 1'b1;  // other values fall back on the kernel clock
    end

    // divide by psc_act+1, only while running
    cnt_clk = 1'b0;
    if (i_counter_run && tick) begin
      if (cur.psc_cnt >= cur.psc_act) begin
        next_cur.psc_cnt = CNT_ZERO;
        cnt_clk = 1'b1;
      end else begin
        next_cur.psc_cnt = cur.psc_cnt + CNT_ONE;
      end
    end

    ovf_ev = 1'b0;
    udf_ev = 1'b0;
    wrap   = 1'b0;
    if (cnt_clk) begin
      if (i_center_align_select) begin
        if (cur.dir == DIR_UP) begin
          if (cur.cnt >= cur.arr_act) begin
            next_cur.cnt = cur.cnt - CNT_ONE;
            next_cur.dir = DIR_DOWN;
          end else begin
            next_cur.cnt = cur.cnt + CNT_ONE;
            // top value is ambiguous; arriving at reload minus one is taken
            ovf_ev = (next_cur.cnt == cur.arr_act - CNT_ONE);
          end
        end else begin
          if (cur.cnt <= CNT_ONE) begin
            next_cur.cnt = cur.cnt - CNT_ONE;
            next_cur.dir = DIR_UP;
            if (cur.cnt == CNT_ZERO) begin
              next_cur.cnt = CNT_ONE;
            end
          end else begin
            next_cur.cnt = cur.cnt - CNT_ONE;
            // flagged as the down-count arrives at one
            udf_ev = (next_cur.cnt == CNT_ONE);
          end
        end
      end else if (!i_dir) begin
        next_cur.dir = DIR_UP;
        if (cur.cnt >= cur.arr_act) begin
          next_cur.cnt = CNT_ZERO;
          ovf_ev = 1'b1;
        end else begin
          next_cur.cnt = cur.cnt + CNT_ONE;
        end
      end else begin
        next_cur.dir = DIR_DOWN;
        if (cur.cnt == CNT_ZERO) begin
          next_cur.cnt = cur.arr_act;
          udf_ev = 1'b1;
        end else begin
          next_cur.cnt = cur.cnt - CNT_ONE;
        end
      end
    end
    wrap = ovf_ev || udf_ev;

    // repetition gate: update after rep_act+1 wraps
    upd_ev = 1'b0;
    if (wrap) begin
      if (cur.rep_cnt == 8'h00) begin
        upd_ev = 1'b1;
      end else begin
        next_cur.rep_cnt = cur.rep_cnt - 8'h01;
      end
    end

    if (i_update_generate) begin
      if (!i_center_align_select && i_dir) begin
        next_cur.cnt = i_auto_reload_value;
        next_cur.dir = DIR_DOWN;
      end else begin
        next_cur.cnt = CNT_ZERO;
        next_cur.dir = DIR_UP;
      end
      next_cur.psc_cnt = CNT_ZERO;
      upd_ev = 1'b1;
    end

    if (i_update_disable) begin
      upd_ev = 1'b0;
    end

    next_cur.upd = upd_ev;
    if (upd_ev) begin
      // shadows land only here, so a mid-run change waits
      next_cur.psc_act = i_prescaler_value;
      next_cur.arr_act = i_auto_reload_value;
      next_cur.rep_act = i_repetition_value;
      next_cur.rep_cnt = i_repetition_value;
      next_cur.psc_cnt = CNT_ZERO;
    end else if (wrap && cur.rep_cnt == 8'h00) begin
      next_cur.rep_cnt = cur.rep_act;
    end

    next_cur.ovf = ovf_ev;
    next_cur.udf = udf_ev;
    // set wins over clear
    if (upd_ev) begin
      next_cur.flag = 1'b1;
    end else if (i_update_flag_clear) begin
      next_cur.flag = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_count        = cur.cnt;
  assign o_dir          = (cur.dir == DIR_DOWN);
  assign o_update_event = cur.upd;
  assign o_update_flag  = cur.flag;
  assign o_overflow     = cur.ovf;
  assign o_underflow    = cur.udf;

  // checks
  upg_clears_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_update_generate && !i_dir && !i_update_disable
    |=> o_count == CNT_ZERO && o_update_event)
    else $error("update generate did not clear counter");
  upg_down_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_update_generate && i_dir && !i_center_align_select
    |=> o_count == $past(i_auto_reload_value))
    else $error("down update generate did not load reload");
  upd_disable_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_update_disable |=> !o_update_event)
    else $error("update event while disabled");
  no_run_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_counter_run && !i_update_generate |=> $stable(o_count))
    else $error("counter moved while stopped");
  up_wrap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_overflow && !i_center_align_select && !$past(i_update_generate)
    |-> o_count == CNT_ZERO)
    else $error("up overflow without wrap to zero");
  down_wrap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_underflow && !i_center_align_select && !$past(i_update_generate)
    |-> o_count == cur.arr_act || o_update_event)
    else $error("down underflow without reload");
  flag_set_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_update_event |-> o_update_flag)
    else $error("update flag missing after update");
  psc_undiv_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    cur.psc_act == CNT_ZERO |-> cur.psc_cnt == CNT_ZERO)
    else $error("undivided prescaler counted");
  shadow_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !o_update_event |-> $stable(cur.psc_act))
    else $error("prescaler changed without update");
  ctr_ovf_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_overflow && i_center_align_select && !$past(i_update_generate)
    |-> o_count == $past(cur.arr_act) - CNT_ONE && !o_dir)
    else $error("center overflow away from reload minus one");
  ctr_udf_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_underflow && i_center_align_select && !$past(i_update_generate)
    |-> o_count == CNT_ONE && o_dir)
    else $error("center underflow away from one");
  upd_cov: cover property (@(posedge i_clk_sys) o_update_event);
  rep_cov: cover property (@(posedge i_clk_sys)
    o_overflow && !o_update_event);
  ovf_cov: cover property (@(posedge i_clk_sys) o_overflow);
  udf_cov: cover property (@(posedge i_clk_sys)
    o_underflow && i_center_align_select);
endmodule
`default_nettype wire

// File: hdl/adv_timer_pkg.sv
/*
  constants and types for the advanced timer counter core.
  assumes a single 25 mhz system clock domain.
*/
package adv_timer_pkg;
  localparam int unsigned CNT_W        = 16;
  localparam logic [3:0]  SRC_KERNEL   = 4'h0;
  localparam logic [3:0]  SRC_ITI0     = 4'h1;
  localparam logic [3:0]  SRC_ITI3     = 4'h4;
  localparam logic [3:0]  SRC_CH0_RISE = 4'h5;
  localparam logic [3:0]  SRC_CH0_FALL = 4'h6;
  localparam logic [3:0]  SRC_CH1_RISE = 4'h7;
  localparam logic [3:0]  SRC_ETI      = 4'h8;
  localparam logic [1:0]  MODE_EDGE    = 2'h0;
  localparam logic [1:0]  MODE_CENTER  = 2'h1;
  localparam logic [3:0]  FILT_LEN_DEF = 4'h4;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_ONE      = 16'h0001;
  typedef enum logic [1:0] {
    DIR_UP   = 2'b00,
    DIR_DOWN = 2'b01
  } dir_state_t;
endpackage

// File: hdl/adv_timer_sync_filter.sv
/*
  three-stage synchroniser and digital filter for one pin input.
  assumes the pin is asynchronous to i_clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module adv_timer_sync_filter
  import adv_timer_pkg::*;
#(
  parameter logic [3:0] FILT_LEN = FILT_LEN_DEF
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);
  typedef struct packed {
    logic [2:0] sync;
    logic [3:0] stable;
    logic       level;
  } flt_state_t;

  flt_state_t cur;
  flt_state_t next_cur;

  // sync[0] feeds only sync[1]; a change counts when stages 2 and 3 agree
  always_comb begin
    next_cur = cur;
    next_cur.sync = {cur.sync[1:0], i_pin};
    if (cur.sync[2] != cur.sync[1] || cur.sync[2] == cur.level) begin
      next_cur.stable = 4'h0;
    end else if (cur.stable >= FILT_LEN) begin
      next_cur.level  = cur.sync[2];
      next_cur.stable = 4'h0;
    end else begin
      next_cur.stable = cur.stable + 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign o_level = cur.level;
endmodule
`default_nettype wire

// File: tb/adv_timer_pin_source.sv
/*
  pin and trigger source standing in for external pins and other timers.
  assumes it shares i_clk_sys with the core; every line idles low.
*/
`timescale 1ns/1ns
`default_nettype none
module adv_timer_pin_source #(
  parameter int HALF = 8
) (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // burst request
  input  wire logic       i_start,
  input  wire logic [2:0] i_line,
  input  wire logic [3:0] i_pulses,
  // lines: triggers 0-3, channel 0, channel 1, external trigger
  output logic [6:0]      o_lines,
  output logic            o_busy
);
  logic [4:0] toggles;
  logic [2:0] sel;
  int         ph;
  // half period above the filter length, so no pulse is swallowed
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_lines <= 7'h00;
      o_busy  <= 1'b0;
      toggles <= 5'h00;
      sel     <= 3'h0;
      ph      <= 0;
    end else if (i_start) begin
      o_busy  <= 1'b1;
      toggles <= {i_pulses, 1'b0};
      sel     <= i_line;
      ph      <= 0;
    end else if (o_busy) begin
      if (ph == HALF - 1) begin
        ph           <= 0;
        o_lines[sel] <= ~o_lines[sel];
        toggles      <= toggles - 5'h01;
        o_busy       <= (toggles != 5'h01);
      end else begin
        ph <= ph + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/test_adv_timer_counter_core.sv
/*
  self-checking bench: every count mode against a cycle model, the
  update-disable case, then every clock source.
  assumes the pin source model drives all pin and trigger inputs.
*/
`timescale 1ns/1ns
`default_nettype none
module test_adv_timer_counter_core;
  import adv_timer_pkg::*;
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic [3:0]  sel = 4'h0;
  logic        mode1 = 1'b0;
  logic        run = 1'b0;
  logic        dir = 1'b0;
  logic        center = 1'b0;
  logic        udis = 1'b0;
  logic        ug = 1'b0;
  logic        fclr = 1'b0;
  logic        start = 1'b0;
  logic [15:0] prescaler_value = 16'h0000;
  logic [15:0] arr = 16'h0000;
  logic [7:0]  rep = 8'h00;
  logic [2:0]  line = 3'h0;
  logic [6:0]  lines;
  logic        busy;
  logic [15:0] count;
  logic        cdir, upd, flag, ovf, unf;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  always #20 i_clk_sys = ~i_clk_sys;

  adv_timer_pin_source u_src (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_start   (start),
    .i_line    (line),
    .i_pulses  (4'h3),
    .o_lines   (lines),
    .o_busy    (busy)
  );

  adv_timer_counter_core u_dut (
    .i_clk_sys                (i_clk_sys),
    .i_rst                    (i_rst),
    .i_timer_source_select    (sel),
    .i_ext_clock_mode1_enable (mode1),
    .i_internal_trigger_inputs(lines[3:0]),
    .i_ch0_in                 (lines[4]),
    .i_ch1_in                 (lines[5]),
    .i_external_trigger_input (lines[6]),
    .i_counter_run            (run),
    .i_dir                    (dir),
    .i_center_align_select    (center),
    .i_update_disable         (udis),
    .i_update_generate        (ug),
    .i_update_flag_clear      (fclr),
    .i_prescaler_value        (prescaler_value),
    .i_auto_reload_value      (arr),
    .i_repetition_value       (rep),
    .o_count                  (count),
    .o_dir                    (cdir),
    .o_update_event           (upd),
    .o_update_flag            (flag),
    .o_overflow               (ovf),
    .o_underflow              (unf)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // drives the configuration except the repetition value, and a software update, in one cycle
  task automatic setup(logic [3:0] s, logic m1, logic [15:0] a,
                       logic [15:0] p, int m, logic d);
    @(posedge i_clk_sys);
    sel    <= s;
    mode1  <= m1;
    arr    <= a;
    prescaler_value    <= p;
    dir    <= (m == 1);
    center <= (m == 2);
    udis   <= d;
    run    <= 1'b1;
    ug     <= 1'b1;
    @(posedge i_clk_sys);
    ug <= 1'b0;
  endtask

  // m: 0 up, 1 down, 2 center; a cycle model runs beside the core
  task automatic run_mode(int m, logic [15:0] a, logic [15:0] p,
                          logic [7:0] r, int n);
    logic [15:0] c, pa, pc, p2, aa;
    logic [7:0]  rc;
    logic        dn, ov, un, u, f;
    p2 = (p + 16'h0001 + 16'($urandom % 3)) % 16'h0004;
    c = (m == 1) ? a : 16'h0000;
    pa = p;
    aa = a;
    pc = 16'h0000;
    rc = r;
    dn = 1'b0;
    f = 1'b1;
    rep <= r;
    setup(SRC_KERNEL, 1'b0, a, p, m, 1'b0);
    @(negedge i_clk_sys);
    check("count after update", count, c);
    check("software update", 16'(upd), 16'h0001);
    for (int k = 1; k <= n; k++) begin
      @(posedge i_clk_sys);
      if (k == 2) prescaler_value <= p2;
      if (k == 2) arr <= a + 16'h0001;
      if (k == n) run <= 1'b0;
      if (k == n) fclr <= 1'b1;
      @(negedge i_clk_sys);
      ov = 1'b0;
      un = 1'b0;
      if (pc != pa) pc++;
      else begin
        pc = 16'h0000;
        if (m == 0) begin
          ov = (c == aa);
          c = ov ? 16'h0000 : c + 16'h0001;
        end else if (m == 1) begin
          un = (c == 16'h0000);
          c = un ? aa : c - 16'h0001;
        end else if (!dn) begin
          c++;
          dn = (c == aa);
          ov = (c == aa - 16'h0001);
        end else begin
          c--;
          dn = (c != 16'h0000);
          un = (c == 16'h0001);
        end
      end
      u = 1'b0;
      if (ov || un) begin
        if (rc == 8'h00) begin
          u = 1'b1;
          rc = r;
          pa = prescaler_value;
          aa = arr;
        end else rc--;
      end
      f = f | u;
      check("count", count, c);
      check("overflow", 16'(ovf), 16'(ov));
      check("underflow", 16'(unf), 16'(un));
      check("update", 16'(upd), 16'(u));
      check("flag", 16'(flag), 16'(f));
      if (m < 2 || (c != 16'h0000 && c != aa))
        check("dir", 16'(cdir), 16'((m == 2) ? dn : (m == 1)));
    end
    @(posedge i_clk_sys);
    fclr <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("count stopped", count, c);
    check("flag cleared", 16'(flag), 16'h0000);
  endtask

  // three pulses on the chosen line must give three counts
  task automatic ext_src(logic [3:0] s, logic m1, logic [2:0] l);
    setup(s, m1, 16'hFFFF, 16'h0000, 0, 1'b0);
    start <= 1'b1;
    line  <= l;
    @(posedge i_clk_sys);
    start <= 1'b0;
    for (int i = 0; i < 200 && (i < 2 || busy); i++) @(posedge i_clk_sys);
    repeat (20) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    check("edge count", count, 16'h0003);
  endtask

  initial begin
    void'($urandom(32'hA7AC53F9));
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    run_mode(0, 16'h0003, 16'h0000, 8'h00, 40);
    for (int m = 0; m < 3; m++)
      for (int j = 0; j < 3; j++)
        run_mode(m, 16'(4 + $urandom % 8), 16'($urandom % 4),
                 8'($urandom % 3), 150);
    setup(SRC_KERNEL, 1'b0, 16'h0004, 16'h0000, 0, 1'b1);
    for (int k = 0; k < 30; k++) begin
      @(negedge i_clk_sys);
      check("update disabled", 16'(upd), 16'h0000);
    end
    for (int s = 1; s < 9; s++)
      ext_src(4'(s), 1'b0, 3'((s < 5) ? s - 1 : (s == 7) ? 5
                             : (s == 8) ? 6 : 4));
    ext_src(SRC_KERNEL, 1'b1, 3'h6);
    print_verdict();
  end
endmodule
`default_nettype wire
